// ===== src/ccc_counter_cmd.sv
// command and status front end of the fast pulse counter, APB slave
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - disabled: no command; run code only refreshes status
// - commands are levels, act every evaluation
// - run command while idle starts counting
// - run when running or disabled only refreshes
// - running continues when enable drops
// - stop command while running returns idle
// - reload copies six values, accumulator kept
// - reload repeats on every enabled evaluation
// - reset loads accumulator, clears status
// - reset does not halt; pulses may drop
// - live count mirrored into configuration field
// - result code reports outcome of evaluation
// - override writes flags only when enabled
// - override carries single shot done flag
// - overflow and underflow flags clearable anytime
// - events clear the opposite setpoint flag
// - modes 0 and 1 wrap to zero
module ccc_counter_cmd
  import ccc_pkg::*;
#(
  parameter logic [7:0] COUNTER_ID = 8'h00
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cnt_pulse_pin,
  input  wire logic              cnt_down_pin,
  output logic [31:0]            out_pattern,
  output logic                   running
);

  ccc_state_t  s_r;
  ccc_state_t  s_nxt;
  ccc_cfg_t    live_cfg;
  logic [31:0] live_acc;
  ccc_flags_t  live_flags;
  ccc_flags_t  ovr_flags;
  logic        eval;
  logic        cfg_load;
  logic        acc_load;
  logic        flags_clr;
  logic        ovr_we;
  logic        access;
  logic        wr;
  logic        en;
  logic [7:0]  cmd;
  logic [7:0]  cid;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_CTRL, OFF_EVAL, OFF_RESULT, OFF_UPPER, OFF_LOWER, OFF_UPAT, OFF_LPAT,
      OFF_OVF, OFF_UNF, OFF_APPACC, OFF_STATUS, OFF_STSACC, OFF_OVR, OFF_OVRRES:
        addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  function automatic logic cfg_ok(input ccc_cfg_t c);
    cfg_ok = (c.upper <= c.ovf) && (c.lower >= c.unf);
  endfunction

  assign access    = psel && penable && !s_r.pready;
  assign wr        = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
  assign en        = s_r.ctrl[CTRL_EN_BIT];
  assign cmd       = s_r.ctrl[CTRL_CMD_LSB +: 8];
  assign cid       = s_r.ctrl[CTRL_ID_LSB +: 8];
  assign ovr_flags = pwdata[OVR_FLAG_LSB +: 5];

  always_comb begin
    s_nxt     = s_r;
    eval      = 1'b0;
    cfg_load  = 1'b0;
    acc_load  = 1'b0;
    flags_clr = 1'b0;
    ovr_we    = 1'b0;
    s_nxt.psync = {s_r.psync[1:0], cnt_pulse_pin};
    s_nxt.dsync = {s_r.dsync[0], cnt_down_pin};
    // bus: one wait state, data and error registered
    s_nxt.pready  = access;
    s_nxt.pslverr = access && !addr_ok(paddr);
    if (access && !pwrite) begin
      unique case (paddr)
        OFF_CTRL:   s_nxt.prdata = s_r.ctrl;
        OFF_RESULT: s_nxt.prdata = {24'h00_0000, s_r.result};
        OFF_UPPER:  s_nxt.prdata = s_r.cfg_app.upper;
        OFF_LOWER:  s_nxt.prdata = s_r.cfg_app.lower;
        OFF_UPAT:   s_nxt.prdata = s_r.cfg_app.upat;
        OFF_LPAT:   s_nxt.prdata = s_r.cfg_app.lpat;
        OFF_OVF:    s_nxt.prdata = s_r.cfg_app.ovf;
        OFF_UNF:    s_nxt.prdata = s_r.cfg_app.unf;
        OFF_APPACC: s_nxt.prdata = s_r.app_acc;
        OFF_STATUS: s_nxt.prdata = {26'h000_0000, s_r.sts_flags, s_r.sts_run};
        OFF_STSACC: s_nxt.prdata = s_r.sts_acc;
        OFF_OVRRES: s_nxt.prdata = {24'h00_0000, s_r.ovr_result};
        default:    s_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // mirror live count unless software wrote it since the last evaluation
    if (!s_r.acc_held) begin
      s_nxt.app_acc = live_acc;
    end
    if (wr) begin
      unique case (paddr)
        OFF_CTRL:   s_nxt.ctrl = pwdata;
        OFF_EVAL:   eval = 1'b1;
        OFF_UPPER:  s_nxt.cfg_app.upper = pwdata;
        OFF_LOWER:  s_nxt.cfg_app.lower = pwdata;
        OFF_UPAT:   s_nxt.cfg_app.upat = pwdata;
        OFF_LPAT:   s_nxt.cfg_app.lpat = pwdata;
        OFF_OVF:    s_nxt.cfg_app.ovf = pwdata;
        OFF_UNF:    s_nxt.cfg_app.unf = pwdata;
        OFF_APPACC: begin
          s_nxt.app_acc  = pwdata;
          s_nxt.acc_held = 1'b1;
        end
        OFF_OVR: begin
          // override applies only when its enable is set
          if (!pwdata[OVR_EN_BIT]) begin
            s_nxt.ovr_result = RES_OFF;
          end else if (pwdata[OVR_ID_LSB +: 8] != COUNTER_ID) begin
            s_nxt.ovr_result = RES_BADID;
          end else begin
            // done flag carried with the others
            ovr_we           = 1'b1;
            s_nxt.ovr_result = RES_OK;
          end
        end
        default: ;
      endcase
    end
    // each evaluation acts on the command held in the control word
    if (eval) begin
      s_nxt.acc_held = 1'b0;
      if (!en) begin
        s_nxt.result = RES_OFF;
        // run code refreshes status even when disabled
        if (cmd == CMD_RUN) begin
          s_nxt.sts_flags = live_flags;
          s_nxt.sts_run   = (s_r.run == CCC_RUN);
          s_nxt.sts_acc   = live_acc;
        end
      end else if (cid != COUNTER_ID) begin
        s_nxt.result = RES_BADID;
      end else begin
        s_nxt.result = RES_OK;
        unique case (cmd)
          CMD_RUN: begin
            // idle to running on a valid configuration
            if (s_r.run == CCC_IDLE) begin
              if (cfg_ok(live_cfg)) begin
                s_nxt.run = CCC_RUN;
              end else begin
                s_nxt.result = RES_CFGERR;
              end
            end
          end
          CMD_STOP: begin
            s_nxt.run = CCC_IDLE;
          end
          CMD_LOAD: begin
            if (cfg_ok(s_r.cfg_app)) begin
              cfg_load = 1'b1;
            end else begin
              s_nxt.result = RES_CFGERR;
            end
          end
          CMD_RESET: begin
            acc_load  = 1'b1;
            flags_clr = 1'b1;
          end
          default: begin
            // reserved or unknown code only reports RES_BADCMD
            s_nxt.result = RES_BADCMD;
          end
        endcase
        if (cmd >= CMD_RUN && cmd <= CMD_RESET) begin
          s_nxt.sts_flags = flags_clr ? '0 : live_flags;
          s_nxt.sts_run   = (s_nxt.run == CCC_RUN);
          s_nxt.sts_acc   = acc_load ? s_r.app_acc : live_acc;
        end
      end
    end
    // only a stop command leaves the running state
    s_nxt.run_o = (s_nxt.run == CCC_RUN);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r         <= '0;
      s_r.cfg_app <= CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ccc_accum u_accum (
    .pclk        (pclk),
    .presetn     (presetn),
    .run         (s_r.run == CCC_RUN),
    .count_pulse (s_r.psync[1] && !s_r.psync[2]),
    .count_down  (s_r.dsync[1]),
    .mode        (s_r.ctrl[CTRL_MODE_LSB +: MODE_W]),
    .cfg_load    (cfg_load),
    .cfg_in      (s_r.cfg_app),
    .acc_load    (acc_load),
    .acc_in      (s_r.app_acc),
    .flags_clr   (flags_clr),
    .ovr_we      (ovr_we),
    .ovr_flags   (ovr_flags),
    .cfg         (live_cfg),
    .acc         (live_acc),
    .flags       (live_flags),
    .out_pattern (out_pattern)
  );

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign running = s_r.run_o;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_eval_ok;
    eval && en && cid == COUNTER_ID;
  endsequence

  sequence s_start_req;
    s_eval_ok ##0 cmd == CMD_RUN && s_r.run == CCC_IDLE && cfg_ok(live_cfg);
  endsequence

  sequence s_load_req;
    s_eval_ok ##0 cmd == CMD_LOAD;
  endsequence

  sequence s_ovr_req;
    wr && paddr == OFF_OVR;
  endsequence

  // evaluation outcome
  a_disabled_idle: assert property (eval && !en
    |=> $stable(s_r.run) && s_r.result == RES_OFF)
    else $error("disabled evaluation changed counting");
  a_no_refresh: assert property (eval && !en && cmd != CMD_RUN
    |=> $stable(s_r.sts_acc) && $stable(s_r.sts_flags))
    else $error("disabled evaluation refreshed status");
  a_run_refresh: assert property (eval && !en && cmd == CMD_RUN
    |=> s_r.sts_acc == $past(live_acc) && $stable(s_r.run))
    else $error("disabled run command did not refresh status");
  a_start_runs: assert property (s_start_req |=> running ##1 running || $past(eval))
    else $error("run command did not start counting");
  a_run_holds: assert property (running
    && !(eval && en && cid == COUNTER_ID && cmd == CMD_STOP) |=> running)
    else $error("counting stopped without a stop command");
  a_stop_idle: assert property (s_eval_ok ##0 cmd == CMD_STOP
    |=> !running && s_r.result == RES_OK)
    else $error("stop command did not halt counting");
  a_reload_copy: assert property (cfg_load |=> live_cfg == $past(s_r.cfg_app))
    else $error("reload did not copy configuration");
  a_reload_ok: assert property (s_load_req ##0 cfg_ok(s_r.cfg_app)
    |=> live_cfg == $past(s_r.cfg_app) && s_r.result == RES_OK)
    else $error("reload evaluation did not load configuration");
  a_reload_err: assert property (s_load_req ##0 !cfg_ok(s_r.cfg_app)
    |=> s_r.result == RES_CFGERR && $stable(live_cfg))
    else $error("bad configuration was loaded");
  a_reset_load: assert property (acc_load
    |=> live_acc == $past(s_r.app_acc) && live_flags == '0)
    else $error("reset did not load accumulator");
  a_reset_status: assert property (s_eval_ok ##0 cmd == CMD_RESET
    |=> s_r.sts_flags == '0 && s_r.sts_acc == $past(s_r.app_acc))
    else $error("reset did not clear status");
  a_reset_runs: assert property (s_eval_ok ##0 cmd == CMD_RESET |=> $stable(s_r.run))
    else $error("reset command changed counting state");
  a_acc_mirror: assert property (!s_r.acc_held && !wr ##1 !s_r.acc_held
    |-> s_r.app_acc == $past(live_acc))
    else $error("configuration accumulator not mirrored");
  a_bad_cmd: assert property (s_eval_ok ##0 (cmd == 8'h00 || cmd > CMD_RESET)
    |=> s_r.result == RES_BADCMD && $stable(s_r.run))
    else $error("invalid command not reported");
  a_bad_id: assert property (eval && en && cid != COUNTER_ID |=> s_r.result == RES_BADID)
    else $error("bad counter identifier not reported");

  // status override and bus answers
  a_ovr_off: assert property (s_ovr_req ##0 !pwdata[OVR_EN_BIT]
    |=> s_r.ovr_result == RES_OFF)
    else $error("disabled override reported action");
  a_ovr_done: assert property (s_ovr_req ##0 pwdata[OVR_EN_BIT]
    && pwdata[OVR_ID_LSB +: 8] == COUNTER_ID
    |=> s_r.ovr_result == RES_OK && (live_flags.done || !$past(ovr_flags.done)))
    else $error("override did not set single shot flag");
  a_ovr_bad_id: assert property (s_ovr_req ##0 pwdata[OVR_EN_BIT]
    && pwdata[OVR_ID_LSB +: 8] != COUNTER_ID |=> s_r.ovr_result == RES_BADID)
    else $error("override with bad identifier not reported");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_slave_err: assert property (access && !addr_ok(paddr) |=> pready && pslverr)
    else $error("unmapped address not refused");

endmodule
`default_nettype wire

// ===== src/ccc_pkg.sv
// shared constants and types of the counter command front end
package ccc_pkg;

  localparam int unsigned DW     = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MODE_W = 4;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_EVAL   = 8'h04;
  localparam logic [7:0] OFF_RESULT = 8'h08;
  localparam logic [7:0] OFF_UPPER  = 8'h0c;
  localparam logic [7:0] OFF_LOWER  = 8'h10;
  localparam logic [7:0] OFF_UPAT   = 8'h14;
  localparam logic [7:0] OFF_LPAT   = 8'h18;
  localparam logic [7:0] OFF_OVF    = 8'h1c;
  localparam logic [7:0] OFF_UNF    = 8'h20;
  localparam logic [7:0] OFF_APPACC = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_STSACC = 8'h2c;
  localparam logic [7:0] OFF_OVR    = 8'h30;
  localparam logic [7:0] OFF_OVRRES = 8'h34;

  // control word fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_CMD_LSB  = 8;
  localparam int unsigned CTRL_ID_LSB   = 16;
  localparam int unsigned CTRL_MODE_LSB = 24;

  // status override word fields
  localparam int unsigned OVR_EN_BIT   = 0;
  localparam int unsigned OVR_FLAG_LSB = 1;
  localparam int unsigned OVR_ID_LSB   = 8;

  // command codes
  localparam logic [7:0] CMD_RUN   = 8'h01;
  localparam logic [7:0] CMD_STOP  = 8'h02;
  localparam logic [7:0] CMD_LOAD  = 8'h03;
  localparam logic [7:0] CMD_RESET = 8'h04;

  // result codes
  localparam logic [7:0] RES_OFF    = 8'h00;
  localparam logic [7:0] RES_OK     = 8'h01;
  localparam logic [7:0] RES_BADCMD = 8'h02;
  localparam logic [7:0] RES_BADID  = 8'h03;
  localparam logic [7:0] RES_CFGERR = 8'h04;

  // highest mode that wraps to zero on upper setpoint or overflow
  localparam logic [3:0] MODE_WRAP_MAX = 4'h1;
  localparam logic [3:0] MODE_SINGLE   = 4'h1;

  typedef enum logic {CCC_IDLE, CCC_RUN} ccc_run_t;

  typedef struct packed {
    logic signed [31:0] upper;
    logic signed [31:0] lower;
    logic [31:0]        upat;
    logic [31:0]        lpat;
    logic signed [31:0] ovf;
    logic signed [31:0] unf;
  } ccc_cfg_t;

  typedef struct packed {
    logic done;
    logic up_hit;
    logic lo_hit;
    logic ovf_seen;
    logic unf_seen;
  } ccc_flags_t;

  localparam ccc_cfg_t CFG_RST = '{
    upper: 32'h0000_03e8, lower: 32'h0000_0000, upat: 32'h0000_0000,
    lpat: 32'h0000_0000, ovf: 32'h7fff_ffff, unf: 32'h8000_0000};

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [31:0]       ctrl;
    logic [7:0]        result;
    logic [7:0]        ovr_result;
    ccc_cfg_t          cfg_app;
    logic [31:0]       app_acc;
    logic              acc_held;
    ccc_flags_t        sts_flags;
    logic              sts_run;
    logic [31:0]       sts_acc;
    ccc_run_t          run;
    logic              run_o;
    logic [2:0]        psync;
    logic [1:0]        dsync;
  } ccc_state_t;

  typedef struct packed {
    ccc_cfg_t   cfg;
    logic [31:0] acc;
    ccc_flags_t flags;
    logic [31:0] outpat;
  } ccc_acc_state_t;

endpackage

// ===== src/ccc_accum.sv
// live accumulator, active setpoints and event flags
`timescale 1ns/1ps
`default_nettype none
module ccc_accum
  import ccc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        count_pulse,
  input  wire logic        count_down,
  input  wire logic [3:0]  mode,
  input  wire logic        cfg_load,
  input  wire ccc_cfg_t    cfg_in,
  input  wire logic        acc_load,
  input  wire logic [31:0] acc_in,
  input  wire logic        flags_clr,
  input  wire logic        ovr_we,
  input  wire ccc_flags_t  ovr_flags,
  output ccc_cfg_t         cfg,
  output logic [31:0]      acc,
  output ccc_flags_t       flags,
  output logic [31:0]      out_pattern
);

  ccc_acc_state_t s_r;
  ccc_acc_state_t s_nxt;
  logic           up_evt;
  logic           lo_evt;
  logic           of_evt;
  logic           uf_evt;

  always_comb begin
    logic signed [31:0] step;
    step   = '0;
    s_nxt  = s_r;
    up_evt = 1'b0;
    lo_evt = 1'b0;
    of_evt = 1'b0;
    uf_evt = 1'b0;
    // new setpoints and limits, accumulator kept
    if (cfg_load) begin
      s_nxt.cfg = cfg_in;
    end
    // load overrides any pulse in the same cycle
    if (acc_load) begin
      s_nxt.acc = acc_in;
    end else if (run && count_pulse) begin
      step = count_down ? $signed(s_r.acc) - 32'sd1 : $signed(s_r.acc) + 32'sd1;
      if (!count_down) begin
        up_evt = (step == s_r.cfg.upper);
        of_evt = (step >= s_r.cfg.ovf);
      end else begin
        lo_evt = (step == s_r.cfg.lower);
        uf_evt = (step <= s_r.cfg.unf);
      end
      // wrap to zero in modes 0 and 1
      if ((mode <= MODE_WRAP_MAX) && (up_evt || of_evt)) begin
        s_nxt.acc = '0;
      end else begin
        s_nxt.acc = step;
      end
    end
    if (ovr_we) begin
      s_nxt.flags = ovr_flags;
    end else if (flags_clr) begin
      s_nxt.flags = '0;
    end
    // events set own flag, clear opposite
    if (up_evt) begin
      s_nxt.flags.up_hit = 1'b1;
      s_nxt.flags.lo_hit = 1'b0;
      s_nxt.outpat       = s_r.cfg.upat;
      if (mode == MODE_SINGLE) begin
        s_nxt.flags.done = 1'b1;
      end
    end
    if (lo_evt) begin
      s_nxt.flags.lo_hit = 1'b1;
      s_nxt.flags.up_hit = 1'b0;
      s_nxt.outpat       = s_r.cfg.lpat;
    end
    if (of_evt || uf_evt) begin
      s_nxt.flags.up_hit = 1'b0;
      s_nxt.flags.lo_hit = 1'b0;
    end
    if (of_evt) begin
      s_nxt.flags.ovf_seen = 1'b1;
    end
    if (uf_evt) begin
      s_nxt.flags.unf_seen = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r     <= '0;
      s_r.cfg <= CFG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cfg         = s_r.cfg;
  assign acc         = s_r.acc;
  assign flags       = s_r.flags;
  assign out_pattern = s_r.outpat;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wrap_zero: assert property ((up_evt || of_evt) && mode <= MODE_WRAP_MAX && !acc_load
    |=> acc == 32'h0000_0000) else $error("accumulator did not wrap to zero");
  a_flag_cross: assert property (up_evt && !lo_evt && !of_evt
    |=> flags.up_hit && !flags.lo_hit)
    else $error("setpoint flags not exclusive after upper event");
  a_ovf_clear: assert property (ovr_we && !of_evt
    |=> flags.ovf_seen == $past(ovr_flags.ovf_seen))
    else $error("overflow flag not written by override");

endmodule
`default_nettype wire

// ===== testbench/ccc_prog_model.sv
// program-side model: APB master that issues counter commands
`timescale 1ns/1ps
`default_nettype none
module ccc_prog_model
  import ccc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var logic         psel,
  output var logic         penable,
  output var logic         pwrite,
  output var logic [7:0]   paddr,
  output var logic [31:0]  pwdata,
  output var logic         timed_out
);
  initial begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    timed_out = 1'b0;
  end

  // request held until pready is seen at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timed_out = 1'b1;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_cmd(input logic en, input logic [7:0] id, input logic [7:0] c);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, OFF_CTRL, 32'h0000_0000, q, e);
    xfer(1'b1, OFF_CTRL, {8'h00, id, c, 7'h00, en}, q, e);
  endtask

  // count written right before one reset
  task automatic force_count(input logic [31:0] v);
    logic [31:0] q;
    logic        e;
    set_cmd(1'b1, 8'h00, CMD_RESET);
    xfer(1'b1, OFF_APPACC, v, q, e);
    xfer(1'b1, OFF_EVAL, 32'h0000_0000, q, e);
    xfer(1'b1, OFF_CTRL, 32'h0000_0000, q, e);
  endtask
endmodule
`default_nettype wire

// ===== testbench/ccc_counter_cmd_tb_top.sv
// self-checking bench of the counter command front end
`timescale 1ns/1ps
`default_nettype none
module ccc_counter_cmd_tb_top
  import ccc_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cnt_pulse_pin;
  logic        cnt_down_pin;
  logic [31:0] out_pattern;
  logic        running;
  logic        timed_out;
  logic [31:0] q;
  logic        e;
  int          num_errors;
  int          comparisons;
  logic [7:0]  bad_codes [3] = '{8'h00, 8'h05, 8'hff};

  ccc_counter_cmd #(.COUNTER_ID(8'h00)) i_ccc_counter_cmd (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cnt_pulse_pin(cnt_pulse_pin),
    .cnt_down_pin(cnt_down_pin), .out_pattern(out_pattern), .running(running));

  ccc_prog_model i_ccc_prog_model (
    .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .timed_out(timed_out));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic wrap_up;
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check_word(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic guard;
    if (timed_out === 1'b1) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ccc_prog_model.xfer(1'b1, a, d, q, e);
    guard();
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    i_ccc_prog_model.xfer(1'b0, a, 32'h0000_0000, q, e);
    guard();
    check_word(nm, x, q);
  endtask

  task automatic cmd(input logic en, input logic [7:0] id, input logic [7:0] c);
    i_ccc_prog_model.set_cmd(en, id, c);
    guard();
  endtask

  task automatic ev(input logic [7:0] res, input logic run);
    wr(OFF_EVAL, 32'h0000_0000);
    rd("result", OFF_RESULT, {24'h0, res});
    check_word("running", {31'h0, run}, {31'h0, running});
  endtask

  task automatic refresh(input logic [31:0] sts, input logic [31:0] acc);
    cmd(1'b1, 8'h00, CMD_RUN);
    ev(RES_OK, 1'b1);
    rd("status", OFF_STATUS, sts);
    rd("status acc", OFF_STSACC, acc);
  endtask

  // pulse high three cycles, low three, then let the synchroniser settle
  task automatic pulses(input int n, input logic dn);
    @(posedge pclk);
    cnt_down_pin <= dn;
    repeat (n) begin
      @(posedge pclk);
      cnt_pulse_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      cnt_pulse_pin <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    num_errors = 0;
    comparisons = 0;
    presetn = 1'b0;
    cnt_pulse_pin = 1'b0;
    cnt_down_pin = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check_word("running", 32'h0, {31'h0, running});
    check_word("out_pattern", 32'h0, out_pattern);
    rd("upper", OFF_UPPER, 32'h0000_03e8);
    rd("ovf", OFF_OVF, 32'h7fff_ffff);
    rd("eval", OFF_EVAL, 32'h0);
    i_ccc_prog_model.xfer(1'b0, 8'h38, 32'h0, q, e);
    guard();
    check_word("pslverr", 32'h1, {31'h0, e});
    check_word("unmapped data", 32'h0, q);
    wr(OFF_RESULT, 32'h0000_00ff);
    rd("result ro", OFF_RESULT, 32'h0);
    cmd(1'b0, 8'h00, CMD_RUN);
    ev(RES_OFF, 1'b0);                  // disabled run
    cmd(1'b1, 8'h05, CMD_RUN);
    ev(RES_BADID, 1'b0);                // bad counter id
    cmd(1'b1, 8'h00, CMD_RUN);
    ev(RES_OK, 1'b1);                   // run starts
    ev(RES_OK, 1'b1);                   // repeated run
    pulses(5, 1'b0);
    rd("app acc", OFF_APPACC, 32'd5);   // live mirror
    cmd(1'b0, 8'h00, CMD_STOP);
    ev(RES_OFF, 1'b1);                  // keeps counting
    rd("status acc", OFF_STSACC, 32'd0); // no refresh
    cmd(1'b0, 8'h00, CMD_RUN);
    ev(RES_OFF, 1'b1);
    rd("status acc", OFF_STSACC, 32'd5); // refresh only
    wr(OFF_UPPER, 32'd8);
    wr(OFF_UPAT, 32'h0000_005a);
    wr(OFF_LPAT, 32'h0000_00a5);
    wr(OFF_OVF, 32'd4);
    cmd(1'b1, 8'h00, CMD_LOAD);
    ev(RES_CFGERR, 1'b1);               // config error
    wr(OFF_OVF, 32'h7fff_ffff);
    ev(RES_OK, 1'b1);                   // level reload
    rd("app acc", OFF_APPACC, 32'd5);   // acc kept
    pulses(3, 1'b0);
    rd("app acc", OFF_APPACC, 32'd0);   // wrap at upper
    check_word("out_pattern", 32'h5a, out_pattern); // new pattern
    refresh(32'h11, 32'd0);             // upper flag set
    pulses(2, 1'b0);
    pulses(2, 1'b1);
    check_word("out_pattern", 32'ha5, out_pattern); // lower pattern
    refresh(32'h09, 32'd0);             // upper flag cleared
    wr(OFF_OVR, 32'h0000_003e);
    rd("ovr result", OFF_OVRRES, 32'h0); // disabled
    refresh(32'h09, 32'd0);             // no change
    // override writes all five flags, setpoint flags included, while counting
    wr(OFF_OVR, 32'h0000_000d);         // hits rewritten unchanged
    refresh(32'h0d, 32'd0);             // flags written
    wr(OFF_OVR, 32'h0000_0009);
    rd("ovr result", OFF_OVRRES, 32'h1); // ok code
    refresh(32'h09, 32'd0);             // cleared running
    wr(OFF_OVR, 32'h0000_0029);
    refresh(32'h29, 32'd0);             // done flag
    wr(OFF_OVR, 32'h0000_0529);
    rd("ovr result", OFF_OVRRES, 32'h3); // bad id
    i_ccc_prog_model.force_count(32'd7); // forced count
    guard();
    rd("result", OFF_RESULT, 32'h1);    // reset done
    refresh(32'h01, 32'd7);             // status cleared
    wr(OFF_CTRL, 32'h0100_0000);        // mode 1, disabled
    pulses(1, 1'b0);
    rd("app acc", OFF_APPACC, 32'd0);   // mode 1 wraps
    refresh(32'h31, 32'd0);             // done and upper set
    foreach (bad_codes[i]) begin
      cmd(1'b1, 8'h00, bad_codes[i]);
      ev(RES_BADCMD, 1'b1);             // invalid code
    end
    cmd(1'b1, 8'h00, CMD_STOP);
    ev(RES_OK, 1'b0);                   // stop
    wr(OFF_OVR, 32'h0000_0001);         // clear while idle
    cmd(1'b0, 8'h00, CMD_RUN);
    ev(RES_OFF, 1'b0);                  // disabled refresh
    rd("status", OFF_STATUS, 32'h0);    // flags cleared
    wrap_up();
  end
endmodule
`default_nettype wire
